// ==== hw/aux_conv_seq.sv ====
// Auxiliary converter sequencer, filter and AXI4-Lite register slave

// Functional notes
// - Each analog control input becomes a 10-bit result.
// - One converter is multiplexed across exactly four input channels.
// - A conversion starts every 896 core clock cycles.
// - Channels rotate so each one refreshes every 3584 cycles.
// - Filter mode register: ch0 bits 7:6 down to ch3 bits 1:0; 15:8 reserved.
// - Mode 00 bypass (default), 01 filtered, 10 1-bit, 11 2-bit hysteresis.
// - A pin reaches the converter only with its 4-bit mode 1101, pins 0-3.
// - Converter results never go into the digital pin value registers.
module aux_conv_seq (
	input  wire logic                       mclk,
	input  wire logic                       rst,
	input  wire logic [aux_pkg::AXI_AW-1:0] s_axi_awaddr,
	input  wire logic                       s_axi_awvalid,
	output logic                            s_axi_awready,
	input  wire logic [aux_pkg::AXI_DW-1:0] s_axi_wdata,
	input  wire logic [3:0]                 s_axi_wstrb,
	input  wire logic                       s_axi_wvalid,
	output logic                            s_axi_wready,
	output logic [1:0]                      s_axi_bresp,
	output logic                            s_axi_bvalid,
	input  wire logic                       s_axi_bready,
	input  wire logic [aux_pkg::AXI_AW-1:0] s_axi_araddr,
	input  wire logic                       s_axi_arvalid,
	output logic                            s_axi_arready,
	output logic [aux_pkg::AXI_DW-1:0]      s_axi_rdata,
	output logic [1:0]                      s_axi_rresp,
	output logic                            s_axi_rvalid,
	input  wire logic                       s_axi_rready,
	input  wire logic [aux_pkg::RES_W-1:0]  conv_data,
	output logic                            conv_start,
	output logic [1:0]                      conv_mux_sel,
	output logic [aux_pkg::CH_NUM-1:0]      conv_pin_connect
);
	import aux_pkg::*;

	// ****************************************************
	// Decode helpers
	// ****************************************************
	function automatic aux_sel_e reg_sel(input logic [AXI_AW-1:0] a);
		if (a == OFS_FILTER_MODE)
			return AUX_SEL_FILTER;
		else if (a == OFS_PIN_MODE)
			return AUX_SEL_PIN;
		else if (a[15:4] == OFS_RESULT_BASE[15:4] && a[1:0] == 2'h0)
			return AUX_SEL_RESULT;
		else
			return AUX_SEL_NONE;
	endfunction : reg_sel

	function automatic aux_fmode_e fmode_of(input logic [7:0] r, input logic [1:0] ch);
		return aux_fmode_e'(r[FMODE_CH0_LSB - 2*ch +: FMODE_W]);
	endfunction : fmode_of

	// ****************************************************
	// Register bus state
	// ****************************************************
	logic                  awready_r, awready_nxt, wready_r, wready_nxt;
	logic                  bvalid_r, bvalid_nxt, arready_r, arready_nxt, rvalid_r, rvalid_nxt;
	logic [1:0]            bresp_r, bresp_nxt, rresp_r, rresp_nxt;
	logic [AXI_DW-1:0]     rdata_r, rdata_nxt;
	logic                  aw_hold_r, aw_hold_nxt, w_hold_r, w_hold_nxt;
	logic [AXI_AW-1:0]     awaddr_r, awaddr_nxt;
	logic [AXI_DW-1:0]     wdata_r, wdata_nxt;
	logic [3:0]            wstrb_r, wstrb_nxt;
	logic [7:0]            fmode_r, fmode_nxt;
	logic [15:0]           pin_mode_r, pin_mode_nxt;
	logic                  aw_take, w_take, ar_take, have_aw, have_w, do_write;
	logic [AXI_AW-1:0]     wa;
	logic [AXI_DW-1:0]     wd;
	logic [3:0]            ws;

	assign aw_take  = s_axi_awvalid & awready_r;
	assign w_take   = s_axi_wvalid & wready_r;
	assign ar_take  = s_axi_arvalid & arready_r;
	assign have_aw  = aw_hold_r | aw_take;
	assign have_w   = w_hold_r | w_take;
	assign do_write = have_aw & have_w;
	assign wa       = aw_hold_r ? awaddr_r : s_axi_awaddr;
	assign wd       = w_hold_r ? wdata_r : s_axi_wdata;
	assign ws       = w_hold_r ? wstrb_r : s_axi_wstrb;

	// ****************************************************
	// Conversion state
	// ****************************************************
	logic [PACE_W-1:0]     pace_r, pace_nxt;
	logic [1:0]            chan_r, chan_nxt;
	logic                  start_r, start_nxt;
	logic [CH_NUM-1:0]     connect_r, connect_nxt;
	logic [FILT_W-1:0]     filt_r [CH_NUM];
	logic [FILT_W-1:0]     filt_nxt [CH_NUM];
	logic [RES_W-1:0]      held_r [CH_NUM];
	logic [RES_W-1:0]      held_nxt [CH_NUM];
	logic                  slot_end;
	aux_fmode_e            cur_mode;
	logic [13:0]           filt_sum;
	logic [RES_W-1:0]      filt_new, hdiff;

	assign slot_end = (pace_r == PACE_LAST);
	assign cur_mode = fmode_of(fmode_r, chan_r);

	always_comb begin
		awready_nxt  = awready_r;
		wready_nxt   = wready_r;
		aw_hold_nxt  = have_aw & ~do_write;
		w_hold_nxt   = have_w & ~do_write;
		awaddr_nxt   = aw_take ? s_axi_awaddr : awaddr_r;
		wdata_nxt    = w_take ? s_axi_wdata : wdata_r;
		wstrb_nxt    = w_take ? s_axi_wstrb : wstrb_r;
		bvalid_nxt   = do_write | (bvalid_r & ~s_axi_bready);
		bresp_nxt    = bresp_r;
		fmode_nxt    = fmode_r;
		pin_mode_nxt = pin_mode_r;
		if (do_write) begin
			bresp_nxt = RESP_OKAY;
			unique case (reg_sel(wa))
				AUX_SEL_FILTER: begin
					if (ws[0])
						fmode_nxt = wd[FMODE_FIELD_W-1:0];
				end
				AUX_SEL_PIN: begin
					if (ws[0])
						pin_mode_nxt[7:0] = wd[7:0];
					if (ws[1])
						pin_mode_nxt[15:8] = wd[15:8];
				end
				AUX_SEL_RESULT: bresp_nxt = RESP_OKAY;
				default: bresp_nxt = RESP_SLVERR;
			endcase
		end
		awready_nxt = ~aw_hold_nxt & ~bvalid_nxt;
		wready_nxt  = ~w_hold_nxt & ~bvalid_nxt;
		rvalid_nxt  = ar_take | (rvalid_r & ~s_axi_rready);
		arready_nxt = ~rvalid_nxt;
		rdata_nxt   = rdata_r;
		rresp_nxt   = rresp_r;
		if (ar_take) begin
			rdata_nxt = '0;
			rresp_nxt = RESP_OKAY;
			unique case (reg_sel(s_axi_araddr))
				AUX_SEL_FILTER: rdata_nxt[FMODE_FIELD_W-1:0] = fmode_r;
				AUX_SEL_PIN:    rdata_nxt[15:0] = pin_mode_r;
				AUX_SEL_RESULT: rdata_nxt[RES_W-1:0] = held_r[s_axi_araddr[3:2]];
				default:        rresp_nxt = RESP_SLVERR;
			endcase
		end
	end

	always_comb begin
		pace_nxt  = slot_end ? '0 : PACE_W'(pace_r + 10'h1);
		start_nxt = slot_end;
		chan_nxt  = slot_end ? 2'(chan_r + 2'h1) : chan_r;
		for (int i = 0; i < CH_NUM; i++) begin
			connect_nxt[i] = (pin_mode_r[i*PIN_MODE_W +: PIN_MODE_W] == PIN_MODE_CONV);
			filt_nxt[i]    = filt_r[i];
			held_nxt[i]    = held_r[i];
		end
		filt_sum = 14'(filt_r[chan_r]) * 14'h3 + 14'({conv_data, 2'h0});
		filt_new = filt_sum[13:4];
		hdiff    = (filt_new > held_r[chan_r]) ? 10'(filt_new - held_r[chan_r]) : 10'(held_r[chan_r] - filt_new);
		if (slot_end && connect_r[chan_r]) begin
			filt_nxt[chan_r] = filt_sum[13:2];
			unique case (cur_mode)
				AUX_FM_BYPASS: begin
					filt_nxt[chan_r] = {conv_data, 2'h0};
					held_nxt[chan_r] = conv_data;
				end
				AUX_FM_FILT: held_nxt[chan_r] = filt_new;
				AUX_FM_HYST1: begin
					if (hdiff > 10'h1)
						held_nxt[chan_r] = filt_new;
				end
				AUX_FM_HYST2: begin
					if (hdiff > 10'h2)
						held_nxt[chan_r] = filt_new;
				end
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			awready_r  <= 1'b0;
			wready_r   <= 1'b0;
			bvalid_r   <= 1'b0;
			bresp_r    <= RESP_OKAY;
			arready_r  <= 1'b0;
			rvalid_r   <= 1'b0;
			rresp_r    <= RESP_OKAY;
			rdata_r    <= '0;
			aw_hold_r  <= 1'b0;
			w_hold_r   <= 1'b0;
			awaddr_r   <= '0;
			wdata_r    <= '0;
			wstrb_r    <= '0;
			fmode_r    <= FILTER_MODE_RST;
			pin_mode_r <= PIN_MODE_RST;
			pace_r     <= '0;
			chan_r     <= '0;
			start_r    <= 1'b0;
			connect_r  <= '0;
			for (int i = 0; i < CH_NUM; i++) begin
				filt_r[i] <= '0;
				held_r[i] <= '0;
			end
		end else begin
			awready_r  <= awready_nxt;
			wready_r   <= wready_nxt;
			bvalid_r   <= bvalid_nxt;
			bresp_r    <= bresp_nxt;
			arready_r  <= arready_nxt;
			rvalid_r   <= rvalid_nxt;
			rresp_r    <= rresp_nxt;
			rdata_r    <= rdata_nxt;
			aw_hold_r  <= aw_hold_nxt;
			w_hold_r   <= w_hold_nxt;
			awaddr_r   <= awaddr_nxt;
			wdata_r    <= wdata_nxt;
			wstrb_r    <= wstrb_nxt;
			fmode_r    <= fmode_nxt;
			pin_mode_r <= pin_mode_nxt;
			pace_r     <= pace_nxt;
			chan_r     <= chan_nxt;
			start_r    <= start_nxt;
			connect_r  <= connect_nxt;
			filt_r     <= filt_nxt;
			held_r     <= held_nxt;
		end
	end

	assign s_axi_awready    = awready_r;
	assign s_axi_wready     = wready_r;
	assign s_axi_bvalid     = bvalid_r;
	assign s_axi_bresp      = bresp_r;
	assign s_axi_arready    = arready_r;
	assign s_axi_rvalid     = rvalid_r;
	assign s_axi_rresp      = rresp_r;
	assign s_axi_rdata      = rdata_r;
	assign conv_start       = start_r;
	assign conv_mux_sel     = chan_r;
	assign conv_pin_connect = connect_r;

	// ****************************************************
	// Checks
	// ****************************************************
	logic [11:0] gap_r;
	logic        seen_r;
	logic [1:0]  last_ch_r;
	logic [11:0] rot_r;

	always_ff @(posedge mclk) begin
		if (rst) begin
			gap_r     <= '0;
			seen_r    <= 1'b0;
			last_ch_r <= '0;
			rot_r     <= 12'hfff; // Channel 0 slot opens at release with no pulse
		end else begin
			gap_r     <= start_r ? 12'h0 : 12'(gap_r + 12'h1);
			seen_r    <= seen_r | start_r;
			last_ch_r <= start_r ? chan_r : last_ch_r;
			rot_r     <= (start_r && chan_r == 2'h0) ? 12'h0 : 12'(rot_r + 12'h1);
		end
	end

	sequence s_slot_end_mode(aux_fmode_e m);
		slot_end && connect_r[chan_r] && cur_mode == m;
	endsequence

	sequence s_write_both;
		s_axi_awvalid && awready_r && s_axi_wvalid && wready_r;
	endsequence

	a_start_spacing: assert property (@(posedge mclk) disable iff (rst)
		start_r && seen_r |-> gap_r == 12'(CONV_PERIOD) - 12'h1) else $error("start spacing wrong");
	a_chan_rotate: assert property (@(posedge mclk) disable iff (rst)
		start_r && seen_r |-> chan_r == 2'(last_ch_r + 2'h1)) else $error("channel not rotated");
	a_chan_refresh: assert property (@(posedge mclk) disable iff (rst)
		start_r && chan_r == 2'h0 && seen_r && rot_r != 12'h0 |-> rot_r == 12'(REFRESH_PERIOD) - 12'h1)
		else $error("channel refresh period wrong");
	a_pin_connect: assert property (@(posedge mclk) disable iff (rst)
		connect_r[0] == $past(pin_mode_r[3:0] == PIN_MODE_CONV)) else $error("pin connect wrong");
	a_bypass_take: assert property (@(posedge mclk) disable iff (rst)
		s_slot_end_mode(AUX_FM_BYPASS) |=> held_r[$past(chan_r)] == $past(conv_data))
		else $error("bypass not taken");
	a_hyst_hold: assert property (@(posedge mclk) disable iff (rst)
		s_slot_end_mode(AUX_FM_HYST2) ##0 hdiff <= 10'h2 |=> held_r[$past(chan_r)] == $past(held_r[chan_r]))
		else $error("hysteresis band moved");
	a_fmode_resv: assert property (@(posedge mclk) disable iff (rst)
		ar_take && reg_sel(s_axi_araddr) == AUX_SEL_FILTER |=> rvalid_r && rdata_r[31:8] == 24'h0)
		else $error("reserved bits set");
	a_result_width: assert property (@(posedge mclk) disable iff (rst)
		ar_take && reg_sel(s_axi_araddr) == AUX_SEL_RESULT |=> rdata_r[31:10] == 22'h0)
		else $error("result wider than 10 bits");
	a_write_resp: assert property (@(posedge mclk) disable iff (rst)
		s_write_both |=> bvalid_r ##0 !awready_r) else $error("write response late");

endmodule : aux_conv_seq

// ==== hw/aux_pkg.sv ====
// Constants and types shared by the auxiliary converter sequencer
package aux_pkg;

	// ****************************************************
	// Bus geometry
	// ****************************************************
	localparam int          AXI_AW            = 16;
	localparam int          AXI_DW            = 32;
	localparam logic [1:0]  RESP_OKAY         = 2'h0;
	localparam logic [1:0]  RESP_SLVERR       = 2'h2;

	// ****************************************************
	// Register offsets (byte addresses)
	// ****************************************************
	localparam logic [15:0] OFS_FILTER_MODE   = 16'he224;
	localparam logic [15:0] OFS_PIN_MODE      = 16'he228;
	localparam logic [15:0] OFS_RESULT_BASE   = 16'he230;

	// ****************************************************
	// Fields and reset values
	// ****************************************************
	localparam int          CH_NUM            = 4;
	localparam int          RES_W             = 10;
	localparam int          FILT_W            = RES_W + 2;
	localparam int          FMODE_W           = 2;
	localparam int          FMODE_CH0_LSB     = 6;
	localparam int          FMODE_FIELD_W     = 8;
	localparam int          PIN_MODE_W        = 4;
	localparam logic [7:0]  FILTER_MODE_RST   = 8'h00;
	localparam logic [15:0] PIN_MODE_RST      = 16'h0000;
	localparam logic [3:0]  PIN_MODE_CONV     = 4'hd;

	// ****************************************************
	// Pacing
	// ****************************************************
	localparam int          CONV_PERIOD       = 896;
	localparam int          REFRESH_PERIOD    = CONV_PERIOD * CH_NUM;
	localparam int          PACE_W            = 10;
	localparam logic [9:0]  PACE_LAST         = 10'(CONV_PERIOD - 1);

	typedef enum logic [1:0] {
		AUX_FM_BYPASS = 2'b00,
		AUX_FM_FILT   = 2'b01,
		AUX_FM_HYST1  = 2'b10,
		AUX_FM_HYST2  = 2'b11
	} aux_fmode_e;

	typedef enum logic [2:0] {
		AUX_SEL_NONE   = 3'b000,
		AUX_SEL_FILTER = 3'b001,
		AUX_SEL_PIN    = 3'b010,
		AUX_SEL_RESULT = 3'b011
	} aux_sel_e;

endpackage : aux_pkg

// ==== tb/aux_conv_model.sv ====
// Behavioural converter model answering for the channel on the multiplexer
module aux_conv_model #(
	parameter int LAT = 16
) (
	input  wire logic        mclk,
	input  wire logic        conv_start,
	input  wire logic [1:0]  conv_mux_sel,
	input  wire logic [39:0] lvl,
	output logic      [9:0]  conv_data
);
	timeunit 1ns;
	timeprecision 1ps;

	int cnt = 0;

	initial conv_data = 10'h155;

	// ********
	// Conversion latency
	// ********
	// Data toggles between its prior value and its inverse until the conversion settles; an early sample is right on alternate cycles only if lvl is unchanged
	always @(posedge mclk) begin
		if (conv_start)
			cnt <= 0;
		else if (cnt < LAT)
			cnt <= cnt + 1;
		if (cnt < LAT)
			conv_data <= ~conv_data;
		else
			conv_data <= lvl[conv_mux_sel*10 +: 10];
	end
endmodule : aux_conv_model

// ==== tb/aux_conv_seq_tb.sv ====
// Self-checking testbench for the auxiliary converter sequencer
module aux_conv_seq_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import aux_pkg::*;

	logic        mclk, rst, awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid, conv_start;
	logic [15:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb, conv_pin_connect;
	logic [1:0]  bresp, rresp, conv_mux_sel;
	logic [9:0]  conv_data;
	logic [39:0] lvl;
	int          err_total, num_checks;

	aux_conv_seq i_dut (.mclk(mclk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .conv_data(conv_data),
		.conv_start(conv_start), .conv_mux_sel(conv_mux_sel), .conv_pin_connect(conv_pin_connect));

	aux_conv_model i_conv (.mclk(mclk), .conv_start(conv_start), .conv_mux_sel(conv_mux_sel),
		.lvl(lvl), .conv_data(conv_data));

	// ********
	// Checking and closing
	// ********
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic end_sim;
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : end_sim

	task automatic hang(input string what);
		err_total++;
		$display("ERROR %s expected done seen timeout", what);
		end_sim();
	endtask : hang

	// ********
	// Register bus master
	// ********
	task automatic axi(input bit wr, input logic [15:0] a, input logic [31:0] d,
			output logic [31:0] q, output logic [1:0] r);
		bit done;
		bit aw_t, w_t, ar_t;
		done = 1'b0;
		@(posedge mclk);
		if (wr) begin
			awaddr  <= a;
			awvalid <= 1'b1;
			wdata   <= d;
			wvalid  <= 1'b1;
			bready  <= 1'b1;
		end else begin
			araddr  <= a;
			arvalid <= 1'b1;
			rready  <= 1'b1;
		end
		for (int n = 0; n < 50 && !done; n++) begin
			@(negedge mclk);
			aw_t = awvalid && awready;
			w_t  = wvalid && wready;
			ar_t = arvalid && arready;
			done = wr ? bvalid : rvalid;
			q    = rdata;
			r    = wr ? bresp : rresp;
			@(posedge mclk);
			if (aw_t)
				awvalid <= 1'b0;
			if (w_t)
				wvalid <= 1'b0;
			if (ar_t)
				arvalid <= 1'b0;
			if (done) begin
				bready <= 1'b0;
				rready <= 1'b0;
			end
		end
		if (!done)
			hang("axi");
	endtask : axi

	task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] er);
		logic [31:0] q;
		logic [1:0]  r;
		axi(1'b1, a, d, q, r);
		chk("bresp", 32'(r), 32'(er));
	endtask : wr

	task automatic rd(input logic [15:0] a, input logic [31:0] ed, input logic [1:0] er);
		logic [31:0] q;
		logic [1:0]  r;
		axi(1'b0, a, 32'h0, q, r);
		chk("rdata", q, ed);
		chk("rresp", 32'(r), 32'(er));
	endtask : rd

	task automatic wait_slot(input logic [1:0] k, output int cyc);
		cyc = 0;
		do begin
			@(negedge mclk);
			cyc++;
		end while (!(conv_start === 1'b1 && conv_mux_sel === k) && cyc < 4000);
		if (cyc >= 4000)
			hang("slot");
	endtask : wait_slot

	// ********
	// Scenarios
	// ********
	task automatic t_reset;
		chk("connect", 32'(conv_pin_connect), 32'h0);
		rd(OFS_FILTER_MODE, 32'h0, RESP_OKAY);
		for (int k = 0; k < 4; k++)
			rd(OFS_RESULT_BASE + 16'(4*k), 32'h0, RESP_OKAY);
		$display("test reset done");
	endtask : t_reset

	task automatic t_regs;
		wr(OFS_FILTER_MODE, 32'hffff, RESP_OKAY);
		rd(OFS_FILTER_MODE, 32'hff, RESP_OKAY);
		wr(OFS_FILTER_MODE, 32'h1b, RESP_OKAY);
		rd(OFS_FILTER_MODE, 32'h1b, RESP_OKAY);
		wr(OFS_RESULT_BASE, 32'h3ff, RESP_OKAY);
		rd(OFS_RESULT_BASE, 32'h0, RESP_OKAY);
		wr(16'he300, 32'h1, RESP_SLVERR);
		rd(16'he300, 32'h0, RESP_SLVERR);
		$display("test registers done");
	endtask : t_regs

	task automatic t_pace;
		int c;
		int tot;
		tot = 0;
		wait_slot(2'd0, c);
		for (int k = 1; k <= 4; k++) begin
			wait_slot(2'(k), c);
			chk("slot", c, 896);
			tot += c;
		end
		chk("refresh", tot, 3584);
		$display("test pacing done");
	endtask : t_pace

	task automatic t_filter;
		int c;
		logic [31:0] e1[4] = '{100, 100, 100, 0};
		logic [31:0] e2[4] = '{100, 102, 102, 0};
		logic [31:0] e3[4] = '{106, 106, 106, 0};
		lvl <= {4{10'd100}};
		wr(OFS_PIN_MODE, 32'hcddd, RESP_OKAY);
		wr(OFS_FILTER_MODE, 32'h0, RESP_OKAY);
		rd(OFS_PIN_MODE, 32'hcddd, RESP_OKAY);
		chk("connect", 32'(conv_pin_connect), 32'h7);
		wait_slot(2'd2, c);
		wait_slot(2'd2, c);
		for (int k = 0; k < 4; k++)
			rd(OFS_RESULT_BASE + 16'(4*k), e1[k], RESP_OKAY);
		wr(OFS_FILTER_MODE, 32'he4, RESP_OKAY);
		@(posedge mclk);
		lvl <= {4{10'd108}};
		wait_slot(2'd2, c);
		for (int k = 0; k < 4; k++)
			rd(OFS_RESULT_BASE + 16'(4*k), e2[k], RESP_OKAY);
		@(posedge mclk);
		lvl <= {4{10'd120}};
		wait_slot(2'd2, c);
		for (int k = 0; k < 4; k++)
			rd(OFS_RESULT_BASE + 16'(4*k), e3[k], RESP_OKAY);
		$display("test filter done");
	endtask : t_filter

	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	initial begin
		rst = 1'b1;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h0;
		{awaddr, araddr} = 32'h0;
		wdata = 32'h0;
		wstrb = 4'hf;
		lvl = 40'h0;
		err_total = 0;
		num_checks = 0;
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		t_reset();
		t_regs();
		t_pace();
		t_filter();
		end_sim();
	end
endmodule : aux_conv_seq_tb
